// ===== lcd_fb_addr_map.svh
// register indices, port addresses and field positions of the lcd frame buffer address bank
`ifndef LCD_FB_ADDR_MAP_SVH
`define LCD_FB_ADDR_MAP_SVH

// indexed port addresses
`define FB_INDEX_PORT    16'h03c4
`define FB_DATA_PORT     16'h03c5

// register indices
`define FB_IDX_RD1_LO    8'h40
`define FB_IDX_RD1_HI    8'h41
`define FB_IDX_RD2_LO    8'h42
`define FB_IDX_RD2_HI    8'h43
`define FB_IDX_RD1_OFS   8'h44
`define FB_IDX_RD_OVF    8'h45
`define FB_IDX_WR_LO     8'h46
`define FB_IDX_WR_HI     8'h47
`define FB_IDX_WR_OFS    8'h48
`define FB_IDX_WR_OVF    8'h49

// read overflow fields
`define RD_OVF_OFS_HI    7:6
`define RD_OVF_RD1_TOP   5:3
`define RD_OVF_RD2_TOP   2:0

// write overflow fields, bits 7:5 reserved
`define WR_OVF_START_TOP 4:2
`define WR_OVF_OFS_HI    1:0
`define WR_OVF_MASK      8'h1f

// offset lands at address bit 3 and up
`define OFS_SHIFT        3
`define REG_RESET        8'h00
`define PANEL_DUAL_SCAN_PASSIVE_PANEL       2'h1

`endif

// ===== lcd_fb_addr_pkg.sv
// types shared by the lcd frame buffer address bank
package lcd_fb_addr_pkg;
  typedef logic [7:0]  reg_byte_type;
  typedef logic [1:0]  panel_sel_type;
  typedef logic [9:0]  line_ofs_type;
  typedef logic [18:0] rd_addr_type;
  typedef logic [21:0] wr_addr_type;
endpackage : lcd_fb_addr_pkg

// ===== lcd_fb_addr_properties.sv
// port assertions for the lcd frame buffer address bank
`include "lcd_fb_addr_map.svh"
module lcd_fb_addr_properties (
  // clock and reset
  input wire logic                          clk_i,
  input wire logic                          rst_n_i,
  // host port
  input wire logic [15:0]                   io_addr_i,
  input wire logic                          io_wr_i,
  input wire logic                          io_rd_i,
  input wire lcd_fb_addr_pkg::reg_byte_type io_wdata_i,
  input wire logic [7:0]                    io_rdata_o,
  input wire logic                          io_hit_o,
  // mode and strobes
  input wire lcd_fb_addr_pkg::panel_sel_type panel_type_i,
  input wire logic                          virtual_refresh_en_i,
  input wire logic                          rd_frame_start_i,
  input wire logic                          rd_line_start_i,
  input wire logic                          wr_frame_start_i,
  input wire logic                          wr_line_start_i,
  // addresses and flags
  input wire logic [18:0]                   rd_fifo1_addr_o,
  input wire logic [18:0]                   rd_fifo2_addr_o,
  input wire logic                          rd_fifo1_upper_half_o,
  input wire logic                          rd_fifo2_active_o,
  input wire logic [21:0]                   wr_addr_o
);
  import lcd_fb_addr_pkg::*;
  reg_byte_type idx_ff;
  logic         dual_w;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // shadow of the index port, so hit checks know the addressed register
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) idx_ff <= 8'h00;
    else if (io_wr_i && io_addr_i == `FB_INDEX_PORT) idx_ff <= io_wdata_i;
  end
  assign dual_w = panel_type_i == `PANEL_DUAL_SCAN_PASSIVE_PANEL && virtual_refresh_en_i;
  sequence data_rd_s;
    rst_n_i && io_rd_i && io_addr_i == `FB_DATA_PORT;
  endsequence
  // a step with no write in flight, so the offset cannot move under it
  sequence rd_step_s;
    rst_n_i && rd_line_start_i && !rd_frame_start_i && !io_wr_i;
  endsequence
  hit_in_bank_a: assert property (data_rd_s ##0 idx_ff inside {[8'h40:8'h49]} |=> io_hit_o)
    else $error("in-bank read gave no hit");
  hit_refused_a: assert property (data_rd_s ##0 !(idx_ff inside {[8'h40:8'h49]})
    |=> !io_hit_o && $stable(io_rdata_o)) else $error("out-of-bank read answered");
  hit_cause_a: assert property (!io_rd_i |=> !io_hit_o) else $error("hit without read");
  rdata_hold_a: assert property (rst_n_i && !io_rd_i |=> $stable(io_rdata_o))
    else $error("read data moved without read");
  mode_flags_a: assert property (rst_n_i |=> rd_fifo1_upper_half_o == $past(dual_w)
    && rd_fifo2_active_o == $past(dual_w)) else $error("mode flags wrong");
  rd1_hold_a: assert property (rst_n_i && !rd_frame_start_i && !rd_line_start_i
    |=> $stable(rd_fifo1_addr_o)) else $error("fifo1 address moved without strobe");
  rd1_align_a: assert property (rd_step_s |=> rd_fifo1_addr_o[2:0] ==
    $past(rd_fifo1_addr_o[2:0])) else $error("fifo1 step touched bits 2:0");
  rd1_even_a: assert property (rd_step_s ##1 rd_step_s |=>
    rd_fifo1_addr_o - $past(rd_fifo1_addr_o) ==
    $past(rd_fifo1_addr_o) - $past(rd_fifo1_addr_o, 2)) else $error("uneven steps");
  fifo2_gate_a: assert property (rst_n_i && !dual_w |=> $stable(rd_fifo2_addr_o))
    else $error("fifo2 address moved outside dual virtual mode");
  wr_align_a: assert property (rst_n_i |=> wr_addr_o[2:0] == 3'h0)
    else $error("write address bits 2:0 not zero");
  wr_hold_a: assert property (rst_n_i && !wr_frame_start_i && !wr_line_start_i
    |=> $stable(wr_addr_o)) else $error("write address moved without strobe");
endmodule : lcd_fb_addr_properties

bind lcd_frame_buffer_address_regs lcd_fb_addr_properties i_lcd_fb_addr_properties (.clk_i,
  .rst_n_i, .io_addr_i, .io_wr_i, .io_rd_i, .io_wdata_i, .io_rdata_o, .io_hit_o, .panel_type_i,
  .virtual_refresh_en_i, .rd_frame_start_i, .rd_line_start_i, .wr_frame_start_i,
  .wr_line_start_i, .rd_fifo1_addr_o, .rd_fifo2_addr_o, .rd_fifo1_upper_half_o,
  .rd_fifo2_active_o, .wr_addr_o);

// ===== lcd_fb_sequencer_model.sv
// far side model: frame and line strobes of the read and write paths
module lcd_fb_sequencer_model (
  // clock
  input  wire logic clk_i,
  // strobes toward the address bank
  output logic      rd_frame_o,
  output logic      rd_line_o,
  output logic      wr_frame_o,
  output logic      wr_line_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] lines = 4'h0;
  assign {wr_line_o, wr_frame_o, rd_line_o, rd_frame_o} = lines;
  // raise one strobe for n edges after gap idle cycles; a long gap models a slow panel
  task automatic strobe(input int which, input int gap, input int n);
    repeat (gap) @(posedge clk_i);
    @(posedge clk_i);
    #1;
    lines[which] = 1'b1;
    repeat (n) @(posedge clk_i);
    #1;
    lines = 4'h0;
  endtask : strobe
endmodule : lcd_fb_sequencer_model

// ===== lcd_frame_buffer_address_regs.sv
// lcd frame buffer start address and line offset registers with line address stepping
`include "lcd_fb_addr_map.svh"

// What this block does
// - fifo1 start feeds standard dual_scan_passive_panel or virtual tft
// - dual_scan_passive_panel virtual refresh: fifo1 serves upper half
// - fifo1 address bits 15:0 from two bytes
// - fifo1 address bits 18:16 from overflow 5:3
// - fifo2 start valid only dual_scan_passive_panel virtual refresh
// - fifo2 address from bytes plus overflow 2:0
// - ten bit fifo1 offset steps each line
// - fifo1 offset low byte hits bits 10:3
// - fifo1 offset bits 9:8 from overflow 7:6
// - write start low byte hits bits 10:3
// - write start high byte hits bits 18:11
// - write overflow start bits hit 21:19
// - ten bit write offset steps each line
// - write offset low byte hits bits 10:3
// - write offset bits 9:8 from overflow 1:0
// - registers reached via index then data port
module lcd_frame_buffer_address_regs (
  // clock and reset
  input  wire logic                          clk_i,
  input  wire logic                          rst_n_i,
  // host i/o port
  input  wire logic [15:0]                   io_addr_i,
  input  wire logic                          io_wr_i,
  input  wire logic                          io_rd_i,
  input  wire lcd_fb_addr_pkg::reg_byte_type io_wdata_i,
  output logic      [7:0]                    io_rdata_o,
  output logic                               io_hit_o,
  // panel mode from the panel control registers, fifo2 offset from a neighbouring bank
  input  wire lcd_fb_addr_pkg::panel_sel_type panel_type_i,
  input  wire logic                          virtual_refresh_en_i,
  input  wire lcd_fb_addr_pkg::line_ofs_type rd_fifo2_offset_i,
  // timing strobes from the flat panel sequencer
  input  wire logic                          rd_frame_start_i,
  input  wire logic                          rd_line_start_i,
  input  wire logic                          wr_frame_start_i,
  input  wire logic                          wr_line_start_i,
  // line addresses and mode flags toward memory controller
  output logic      [18:0]                   rd_fifo1_addr_o,
  output logic      [18:0]                   rd_fifo2_addr_o,
  output logic                               rd_fifo1_upper_half_o,
  output logic                               rd_fifo2_active_o,
  output logic      [21:0]                   wr_addr_o
);
  import lcd_fb_addr_pkg::*;

  // decode of an i/o address used for both the index and data ports
  function automatic logic port_is(input logic [15:0] addr, input logic [15:0] port);
    port_is = (addr == port);
  endfunction : port_is

  // decode of the bank's own index range
  function automatic logic idx_in_bank(input reg_byte_type idx);
    idx_in_bank = (idx >= `FB_IDX_RD1_LO) && (idx <= `FB_IDX_WR_OVF);
  endfunction : idx_in_bank

  // register bank state
  reg_byte_type index_ff;
  reg_byte_type nxt_index;

  // the ten bytes of the bank
  reg_byte_type rd1_lo_ff;
  reg_byte_type nxt_rd1_lo;
  reg_byte_type rd1_hi_ff;
  reg_byte_type nxt_rd1_hi;
  reg_byte_type rd2_lo_ff;
  reg_byte_type nxt_rd2_lo;
  reg_byte_type rd2_hi_ff;
  reg_byte_type nxt_rd2_hi;
  reg_byte_type rd1_ofs_ff;
  reg_byte_type nxt_rd1_ofs;
  reg_byte_type rd_ovf_ff;
  reg_byte_type nxt_rd_ovf;
  reg_byte_type wr_lo_ff;
  reg_byte_type nxt_wr_lo;
  reg_byte_type wr_hi_ff;
  reg_byte_type nxt_wr_hi;
  reg_byte_type wr_ofs_ff;
  reg_byte_type nxt_wr_ofs;
  reg_byte_type wr_ovf_ff;
  reg_byte_type nxt_wr_ovf;

  // read answer state
  reg_byte_type rdata_ff;
  reg_byte_type nxt_rdata;
  logic         hit_ff;
  logic         nxt_hit;

  // line address state
  rd_addr_type  rd1_line_ff;
  rd_addr_type  nxt_rd1_line;
  rd_addr_type  rd2_line_ff;
  rd_addr_type  nxt_rd2_line;
  wr_addr_type  wr_line_ff;
  wr_addr_type  nxt_wr_line;
  logic         upper_ff;
  logic         nxt_upper;
  logic         rd2_act_ff;
  logic         nxt_rd2_act;

  // assembled programmed values
  rd_addr_type  rd1_start;
  rd_addr_type  rd2_start;
  wr_addr_type  wr_start;

  // ten bit offsets and their steps at address bit 3
  line_ofs_type rd1_ofs;
  line_ofs_type wr_ofs;
  rd_addr_type  rd1_step;
  rd_addr_type  rd2_step;
  wr_addr_type  wr_step;

  // decoded port strobes and panel mode
  logic         data_wr;
  logic         data_rd;
  logic         dual_vr;

  // register fields laid onto address bits
  assign rd1_start = {rd_ovf_ff[`RD_OVF_RD1_TOP], rd1_hi_ff, rd1_lo_ff};
  assign rd2_start = {rd_ovf_ff[`RD_OVF_RD2_TOP], rd2_hi_ff, rd2_lo_ff};
  // write start bytes sit above bits 2:0, which stay zero on the write side
  assign wr_start  = {wr_ovf_ff[`WR_OVF_START_TOP], wr_hi_ff, wr_lo_ff,
                      3'h0};
  // ten bit offsets: a low byte plus two overflow bits
  assign rd1_ofs   = {rd_ovf_ff[`RD_OVF_OFS_HI], rd1_ofs_ff};
  assign wr_ofs    = {wr_ovf_ff[`WR_OVF_OFS_HI], wr_ofs_ff};
  // offsets sit at bit 3, so bits 7:0 land on 10:3 and 9:8 on 12:11
  assign rd1_step  = 19'(rd1_ofs) << `OFS_SHIFT;
  // the fifo2 offset lives in a neighbouring bank and arrives on a port
  assign rd2_step  = 19'(rd_fifo2_offset_i) << `OFS_SHIFT;
  assign wr_step   = 22'(wr_ofs) << `OFS_SHIFT;

  // port strobes; the index port is shared, we only shadow its value
  assign data_wr = io_wr_i && port_is(io_addr_i, `FB_DATA_PORT);
  assign data_rd = io_rd_i && port_is(io_addr_i, `FB_DATA_PORT);
  // a dual scan passive panel in virtual refresh splits into two halves
  assign dual_vr = (panel_type_i == `PANEL_DUAL_SCAN_PASSIVE_PANEL) && virtual_refresh_en_i;

  // next values of the register bank
  always_comb begin
    nxt_index   = index_ff;
    nxt_rd1_lo  = rd1_lo_ff;
    nxt_rd1_hi  = rd1_hi_ff;
    nxt_rd2_lo  = rd2_lo_ff;
    nxt_rd2_hi  = rd2_hi_ff;
    nxt_rd1_ofs = rd1_ofs_ff;
    nxt_rd_ovf  = rd_ovf_ff;
    nxt_wr_lo   = wr_lo_ff;
    nxt_wr_hi   = wr_hi_ff;
    nxt_wr_ofs  = wr_ofs_ff;
    nxt_wr_ovf  = wr_ovf_ff;
    if (io_wr_i && port_is(io_addr_i, `FB_INDEX_PORT)) begin
      nxt_index = io_wdata_i;
    end
    // a data write is steered by the index taken at an earlier edge
    if (data_wr) begin
      unique case (index_ff)
        `FB_IDX_RD1_LO:  nxt_rd1_lo  = io_wdata_i;
        `FB_IDX_RD1_HI:  nxt_rd1_hi  = io_wdata_i;
        `FB_IDX_RD2_LO:  nxt_rd2_lo  = io_wdata_i;
        `FB_IDX_RD2_HI:  nxt_rd2_hi  = io_wdata_i;
        `FB_IDX_RD1_OFS: nxt_rd1_ofs = io_wdata_i;
        `FB_IDX_RD_OVF:  nxt_rd_ovf  = io_wdata_i;
        `FB_IDX_WR_LO:   nxt_wr_lo   = io_wdata_i;
        `FB_IDX_WR_HI:   nxt_wr_hi   = io_wdata_i;
        `FB_IDX_WR_OFS:  nxt_wr_ofs  = io_wdata_i;
        // reserved top bits are dropped here so they always read back as zero
        `FB_IDX_WR_OVF:  nxt_wr_ovf  = io_wdata_i & `WR_OVF_MASK;
        default:         nxt_index   = index_ff; // other banks own it
      endcase
    end
  end

  // register bank flops; contents are cleared only to keep simulation
  // deterministic, software must still program them before use
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      index_ff   <= `REG_RESET;
      rd1_lo_ff  <= `REG_RESET;
      rd1_hi_ff  <= `REG_RESET;
      rd2_lo_ff  <= `REG_RESET;
      rd2_hi_ff  <= `REG_RESET;
      rd1_ofs_ff <= `REG_RESET;
      rd_ovf_ff  <= `REG_RESET;
      wr_lo_ff   <= `REG_RESET;
      wr_hi_ff   <= `REG_RESET;
      wr_ofs_ff  <= `REG_RESET;
      wr_ovf_ff  <= `REG_RESET;
    end else begin
      index_ff   <= nxt_index;
      rd1_lo_ff  <= nxt_rd1_lo;
      rd1_hi_ff  <= nxt_rd1_hi;
      rd2_lo_ff  <= nxt_rd2_lo;
      rd2_hi_ff  <= nxt_rd2_hi;
      rd1_ofs_ff <= nxt_rd1_ofs;
      rd_ovf_ff  <= nxt_rd_ovf;
      wr_lo_ff   <= nxt_wr_lo;
      wr_hi_ff   <= nxt_wr_hi;
      wr_ofs_ff  <= nxt_wr_ofs;
      wr_ovf_ff  <= nxt_wr_ovf;
    end
  end

  // next read answer; it holds until the next in-bank read so slow hosts can sample late
  always_comb begin
    nxt_rdata = rdata_ff;
    nxt_hit   = 1'b0;
    // a read outside the bank leaves the answer alone so another bank can own the mux
    if (data_rd && idx_in_bank(index_ff)) begin
      nxt_hit = 1'b1;
      unique case (index_ff)
        `FB_IDX_RD1_LO:  nxt_rdata = rd1_lo_ff;
        `FB_IDX_RD1_HI:  nxt_rdata = rd1_hi_ff;
        `FB_IDX_RD2_LO:  nxt_rdata = rd2_lo_ff;
        `FB_IDX_RD2_HI:  nxt_rdata = rd2_hi_ff;
        `FB_IDX_RD1_OFS: nxt_rdata = rd1_ofs_ff;
        `FB_IDX_RD_OVF:  nxt_rdata = rd_ovf_ff;
        `FB_IDX_WR_LO:   nxt_rdata = wr_lo_ff;
        `FB_IDX_WR_HI:   nxt_rdata = wr_hi_ff;
        `FB_IDX_WR_OFS:  nxt_rdata = wr_ofs_ff;
        `FB_IDX_WR_OVF:  nxt_rdata = wr_ovf_ff;
        default:         nxt_rdata = `REG_RESET;
      endcase
    end
  end

  // read answer flops
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_ff <= `REG_RESET;
      hit_ff   <= 1'b0;
    end else begin
      rdata_ff <= nxt_rdata;
      hit_ff   <= nxt_hit;
    end
  end

  // next read line addresses; frame start wins over a line strobe in the same cycle
  always_comb begin
    nxt_rd1_line = rd1_line_ff;
    nxt_rd2_line = rd2_line_ff;
    nxt_upper    = dual_vr;
    nxt_rd2_act  = dual_vr;
    if (rd_frame_start_i) begin
      nxt_rd1_line = rd1_start;
      nxt_rd2_line = dual_vr ? rd2_start : rd2_line_ff;
    end else if (rd_line_start_i) begin
      nxt_rd1_line = rd1_line_ff + rd1_step;
      // fifo2 keeps its last line outside dual scan virtual refresh
      if (dual_vr) begin
        nxt_rd2_line = rd2_line_ff + rd2_step;
      end
    end
  end

  // read line address flops; sums wrap at the top of the 19 bit space
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rd1_line_ff <= '0;
      rd2_line_ff <= '0;
      upper_ff    <= 1'b0;
      rd2_act_ff  <= 1'b0;
    end else begin
      rd1_line_ff <= nxt_rd1_line;
      rd2_line_ff <= nxt_rd2_line;
      upper_ff    <= nxt_upper;
      rd2_act_ff  <= nxt_rd2_act;
    end
  end

  // next write line address; same frame over line priority as the read side
  always_comb begin
    nxt_wr_line = wr_line_ff;
    // a frame strobe reloads, so a wrong offset never drifts across frames
    if (wr_frame_start_i) begin
      nxt_wr_line = wr_start;
    end else if (wr_line_start_i) begin
      nxt_wr_line = wr_line_ff + wr_step;
    end
  end

  // write line address flop
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wr_line_ff <= '0;
    end else begin
      wr_line_ff <= nxt_wr_line;
    end
  end

  // every output straight from a flop
  assign io_rdata_o            = rdata_ff;
  assign io_hit_o              = hit_ff;
  assign rd_fifo1_addr_o       = rd1_line_ff;
  assign rd_fifo2_addr_o       = rd2_line_ff;
  assign rd_fifo1_upper_half_o = upper_ff;
  assign rd_fifo2_active_o     = rd2_act_ff;
  assign wr_addr_o             = wr_line_ff;

endmodule : lcd_frame_buffer_address_regs

// ===== test_lcd_frame_buffer_address_regs.sv
// self-checking bench for the lcd frame buffer address bank
`include "lcd_fb_addr_map.svh"
module test_lcd_frame_buffer_address_regs;
  timeunit 1ns;
  timeprecision 1ps;
  import lcd_fb_addr_pkg::*;
  logic          clk_i = 1'b0;
  logic          rst_n_i = 1'b0;
  logic [15:0]   io_addr_i = 16'h0000;
  logic          io_wr_i = 1'b0;
  logic          io_rd_i = 1'b0;
  reg_byte_type  io_wdata_i = 8'h00;
  panel_sel_type panel_type_i = 2'h0;
  logic          vr_en = 1'b0;
  line_ofs_type  fifo2_ofs = 10'h000;
  logic          rd_fr, rd_ln, wr_fr, wr_ln, hit, upper, active;
  logic [7:0]    rdata;
  logic [18:0]   rd1, rd2;
  logic [21:0]   wr_addr;
  int            num_errors = 0;
  int            check_count = 0;
  int            cycles = 0;
  lcd_frame_buffer_address_regs i_lcd_frame_buffer_address_regs (.clk_i, .rst_n_i, .io_addr_i,
    .io_wr_i, .io_rd_i, .io_wdata_i, .io_rdata_o(rdata), .io_hit_o(hit), .panel_type_i,
    .virtual_refresh_en_i(vr_en), .rd_fifo2_offset_i(fifo2_ofs), .rd_frame_start_i(rd_fr),
    .rd_line_start_i(rd_ln), .wr_frame_start_i(wr_fr), .wr_line_start_i(wr_ln),
    .rd_fifo1_addr_o(rd1), .rd_fifo2_addr_o(rd2), .rd_fifo1_upper_half_o(upper),
    .rd_fifo2_active_o(active), .wr_addr_o(wr_addr));
  lcd_fb_sequencer_model i_lcd_fb_sequencer_model (.clk_i, .rd_frame_o(rd_fr),
    .rd_line_o(rd_ln), .wr_frame_o(wr_fr), .wr_line_o(wr_ln));
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // one strobed cycle on the host port; answers are settled when this returns
  task automatic io(input logic wr, input logic rd, input logic [15:0] a, input reg_byte_type d);
    @(posedge clk_i);
    #1;
    io_wr_i = wr;
    io_rd_i = rd;
    io_addr_i = a;
    io_wdata_i = d;
    @(posedge clk_i);
    #1;
    io_wr_i = 1'b0;
    io_rd_i = 1'b0;
  endtask : io
  task automatic reg_wr(input reg_byte_type idx, input reg_byte_type d);
    io(1'b1, 1'b0, `FB_INDEX_PORT, idx);
    io(1'b1, 1'b0, `FB_DATA_PORT, d);
  endtask : reg_wr
  task automatic reg_rd(input reg_byte_type idx, input reg_byte_type exp, input logic hit_exp);
    io(1'b1, 1'b0, `FB_INDEX_PORT, idx);
    io(1'b0, 1'b1, `FB_DATA_PORT, 8'h00);
    check("io_hit_o", {31'h0, hit}, {31'h0, hit_exp});
    check("io_rdata_o", {24'h0, rdata}, {24'h0, exp});
  endtask : reg_rd
  // distinct values everywhere; reserved write overflow bits read back as zero
  task automatic t_regs();
    for (int i = 0; i < 10; i++) begin
      reg_wr(8'h40 + 8'(i), 8'ha0 + 8'(i));
    end
    for (int i = 0; i < 10; i++) begin
      reg_rd(8'h40 + 8'(i), (i == 9) ? 8'h09 : 8'ha0 + 8'(i), 1'b1);
    end
    reg_rd(8'h4a, 8'h09, 1'b0);
    $display("test regs done");
  endtask : t_regs
  // standard refresh: fifo1 loads and takes two back to back steps, fifo2 stays idle
  task automatic t_read();
    logic [18:0] exp;
    reg_wr(`FB_IDX_RD1_LO, 8'h12);
    reg_wr(`FB_IDX_RD1_HI, 8'h34);
    reg_wr(`FB_IDX_RD2_LO, 8'h9a);
    reg_wr(`FB_IDX_RD2_HI, 8'hbc);
    reg_wr(`FB_IDX_RD1_OFS, 8'h56);
    reg_wr(`FB_IDX_RD_OVF, 8'hab);
    i_lcd_fb_sequencer_model.strobe(0, 0, 1);
    exp = {3'h5, 8'h34, 8'h12};
    check("rd_fifo1_addr_o", 32'(rd1), 32'(exp));
    check("rd_fifo2_addr_o", 32'(rd2), 32'h0);
    check("rd_fifo1_upper_half_o", {31'h0, upper}, 32'h0);
    i_lcd_fb_sequencer_model.strobe(1, 3, 2);
    exp = 19'(exp + {2'h2, 8'h56, 3'h0} * 2);
    check("rd_fifo1_addr_o", 32'(rd1), 32'(exp));
    $display("test read done");
  endtask : t_read
  // dual scan virtual refresh: fifo1 upper half, fifo2 lower half with its own step
  task automatic t_dual();
    logic [18:0] exp;
    panel_type_i = `PANEL_DUAL_SCAN_PASSIVE_PANEL;
    vr_en = 1'b1;
    fifo2_ofs = 10'h3ff;
    i_lcd_fb_sequencer_model.strobe(0, 0, 1);
    check("rd_fifo1_upper_half_o", {31'h0, upper}, 32'h1);
    check("rd_fifo2_active_o", {31'h0, active}, 32'h1);
    check("rd_fifo1_addr_o", 32'(rd1), 32'(19'h53412));
    exp = {3'h3, 8'hbc, 8'h9a};
    check("rd_fifo2_addr_o", 32'(rd2), 32'(exp));
    i_lcd_fb_sequencer_model.strobe(1, 0, 1);
    exp = exp + {10'h3ff, 3'h0};
    check("rd_fifo2_addr_o", 32'(rd2), 32'(exp));
    check("rd_fifo1_addr_o", 32'(rd1), 32'(19'h546c2));
    $display("test dual done");
  endtask : t_dual
  // panel code 2, not dual scan, in virtual refresh: fifo1 serves all, fifo2 stays parked
  task automatic t_tft();
    panel_type_i = 2'h2;
    i_lcd_fb_sequencer_model.strobe(0, 0, 1);
    check("rd_fifo1_upper_half_o", {31'h0, upper}, 32'h0);
    check("rd_fifo2_active_o", {31'h0, active}, 32'h0);
    check("rd_fifo1_addr_o", 32'(rd1), 32'(19'h53412));
    i_lcd_fb_sequencer_model.strobe(1, 0, 1);
    check("rd_fifo1_addr_o", 32'(rd1), 32'(19'h546c2));
    check("rd_fifo2_addr_o", 32'(rd2), 32'(19'h3dc92));
    $display("test tft done");
  endtask : t_tft
  // write path load and three back to back steps with offset bit 8 set and bit 9 clear
  task automatic t_write();
    logic [21:0] exp;
    reg_wr(`FB_IDX_WR_LO, 8'hcd);
    reg_wr(`FB_IDX_WR_HI, 8'hef);
    reg_wr(`FB_IDX_WR_OFS, 8'h77);
    reg_wr(`FB_IDX_WR_OVF, 8'h19);
    i_lcd_fb_sequencer_model.strobe(2, 0, 1);
    exp = {3'h6, 8'hef, 8'hcd, 3'h0};
    check("wr_addr_o", 32'(wr_addr), 32'(exp));
    i_lcd_fb_sequencer_model.strobe(3, 2, 3);
    exp = 22'(exp + {2'h1, 8'h77, 3'h0} * 3);
    check("wr_addr_o", 32'(wr_addr), 32'(exp));
    $display("test write done");
  endtask : t_write
  // mid-run reset clears outputs and bank, then the port answers again at once
  task automatic t_reset();
    @(posedge clk_i);
    #1;
    rst_n_i = 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    rst_n_i = 1'b1;
    check("rd_fifo1_addr_o", 32'(rd1), 32'h0);
    check("rd_fifo2_addr_o", 32'(rd2), 32'h0);
    check("wr_addr_o", 32'(wr_addr), 32'h0);
    check("rd_fifo2_active_o", {31'h0, active}, 32'h0);
    reg_rd(`FB_IDX_WR_OFS, 8'h00, 1'b1);
    $display("test reset done");
  endtask : t_reset
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test
  // the whole run needs well under a thousand cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      finish_test();
    end
  end
  initial begin
    repeat (20) @(posedge clk_i);
    #1;
    rst_n_i = 1'b1;
    check("wr_addr_o", 32'(wr_addr), 32'h0);
    t_regs();
    t_read();
    t_dual();
    t_tft();
    t_write();
    t_reset();
    finish_test();
  end
endmodule : test_lcd_frame_buffer_address_regs
